// ---- spc_pkg.sv ----
// Package for the suspend power control block: register map, timing counts, state and
// control carriers.
// Assumes a single 100 MHz sys_clk and no bus beyond the power-management I/O port.
package spc_pkg;
  // Register offsets within the power-management I/O block
  localparam logic [7:0] SPC_OFF_GPI = 8'h30;
  localparam logic [7:0] SPC_OFF_GPO = 8'h34;
  localparam logic [30:0] SPC_GPO_RESET = 31'h0000_0000;
  localparam int SPC_GPI_W = 22;
  localparam int SPC_GPO_W = 31;
  // Positions of shared pins within the input and output groups
  localparam int SPC_GPI_THERMAL = 8;
  localparam int SPC_GPI_LID = 10;
  localparam int SPC_GPI_ALERT = 11;
  localparam int SPC_GPI_RING = 12;
  localparam int SPC_GPO_POWEROFF = 8;
  localparam int SPC_GPO_PLANE_B = 15;
  localparam int SPC_GPO_PLANE_C = 16;
  localparam int SPC_GPO_BUS_STOP = 18;
  localparam int SPC_GPO_SRAM = 19;
  localparam int SPC_GPO_HOST_STAT = 20;
  localparam int SPC_GPO_PERIPH = 21;
  // Timing
  localparam int SPC_CLK_MHZ = 100;
  localparam int SPC_DEBOUNCE_MS = 16;
  localparam int SPC_DEBOUNCE_CYC = SPC_DEBOUNCE_MS * 1000 * SPC_CLK_MHZ;
  localparam int SPC_THROTTLE_TICK_CYC = 256;
  localparam logic [15:0] SPC_BOOT_TOP = 16'hffff;

  typedef enum logic [1:0] {
    SPC_WORKING = 2'b00,
    SPC_POS = 2'b01,
    SPC_STR = 2'b11,
    SPC_STD = 2'b10
  } spc_state_t;

  typedef enum logic [1:0] {
    SPC_ROUTE_IRQ = 2'b00,
    SPC_ROUTE_SMI = 2'b01,
    SPC_ROUTE_RESUME = 2'b10
  } spc_route_t;

  // Software-set controls of the power-management logic
  typedef struct packed {
    logic lidSmiEn;
    logic alertEn;
    spc_route_t alertRoute;
    logic throttleEn;
    logic [3:0] throttleRate;
    logic stopClockReq;
    logic busStopReq;
    logic smiClear;
  } spc_ctl_t;

  // Pin function selects: 1 hands the pin to general-purpose use
  typedef struct packed {
    logic lidAsGpi;
    logic alertAsGpi;
    logic thermalAsGpi;
    logic planeBAsGpo;
    logic planeCAsGpo;
    logic busStopAsGpo;
    logic sramAsGpo;
    logic hostStatAsGpo;
    logic periphAsGpo;
  } spc_pinsel_t;
endpackage : spc_pkg

// ---- suspend_power_control.sv ----
// Suspend power control: debounced lid and power button, event routing, power plane and
// suspend status pins, throttling, resets, general-purpose pins, straps and speaker.
// Assumes pin inputs are asynchronous and the I/O port is decoded against pm_io_base.
`timescale 1ns/1ns
module suspend_power_control
  import spc_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = SPC_DEBOUNCE_CYC
) (
  // Clock and resets
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic resume_reset_n,
  input wire logic power_good,
  // Event and strap pins
  input wire logic power_button_n,
  input wire logic [SPC_GPI_W-1:0] general_input,
  input wire logic cpu_type_select,
  input wire logic boot_range_decode_select,
  // Internal controls
  input wire spc_state_t sleepState,
  input wire spc_ctl_t pmCtl,
  input wire spc_pinsel_t pinSel,
  input wire logic cpuInitReq,
  input wire logic timer2Out,
  input wire logic speakerGate,
  input wire logic [31:0] memAddr,
  // Power-management I/O port
  input wire logic pmIoSel,
  input wire logic pmIoRd,
  input wire logic pmIoWr,
  input wire logic [7:0] pmIoAddr,
  input wire logic [31:0] pmIoWrData,
  output logic [31:0] pmIoRdData,
  output logic pmIoAck,
  // Plane and status pins
  output logic primary_plane_ctl_n,
  output logic secondary_plane_ctl_n,
  output logic tertiary_plane_ctl_n,
  output logic host_clock_status_n,
  output logic peripheral_suspend_status_n,
  output logic bus_clock_stop_n,
  output logic cpu_clock_stop_req_n,
  output logic cache_sram_sleep_n,
  // Events
  output logic sys_mgmt_irq_n,
  output logic alertIrq,
  output logic alertResume,
  output logic powerButtonLevel,
  // Resets, decode and speaker
  output logic processor_reset,
  output logic processor_init,
  output logic bus_reset_n,
  output logic expansion_reset,
  output logic topRangePositive,
  output logic speaker_out,
  // General outputs
  output logic [SPC_GPO_W-1:0] general_output
);
  localparam int DW = $clog2(SPC_DEBOUNCE_CYC + 1);
  localparam logic [DW-1:0] DB_LAST = DW'(DEBOUNCE_CYCLES - 1);
  localparam logic [7:0] TICK_LAST = 8'(SPC_THROTTLE_TICK_CYC - 1);

  // Two-flop synchronisers for every asynchronous pin
  localparam int SW = SPC_GPI_W + 5;
  logic [SW-1:0] syncA_r;
  logic [SW-1:0] syncB_r;
  wire [SW-1:0] rawPins = {general_input, power_button_n, resume_reset_n, power_good,
                           cpu_type_select, boot_range_decode_select};
  always_ff @(posedge sys_clk) begin
    syncA_r <= rawPins;
    syncB_r <= syncA_r;
  end
  wire [SPC_GPI_W-1:0] gpiSync = syncB_r[SW-1:5];
  wire pwrBtnSync = syncB_r[4];
  wire rsmSync = syncB_r[3];
  wire pwrOkSync = syncB_r[2];
  wire cpuTypeSync = syncB_r[1];
  wire bootSelSync = syncB_r[0];

  // Suspend-well pins are held while either reset is active, the debouncers by resume reset only
  wire wellRst = ~rsmSync;
  wire anyRst = ~reset_n | wellRst;

  // Debouncers: index 0 lid, index 1 power button
  logic [1:0] dbIn;
  logic [1:0] dbOut;
  logic [1:0] dbEdge;
  assign dbIn = {pwrBtnSync, gpiSync[SPC_GPI_LID]};
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gDeb
      logic [DW-1:0] cnt_r;
      logic level_r;
      logic edge_r;
      wire differs = dbIn[g] != level_r;
      always_ff @(posedge sys_clk) begin
        if (wellRst) begin
          cnt_r <= '0;
          level_r <= 1'b1;
          edge_r <= 1'b0;
        end else begin
          edge_r <= 1'b0;
          if (!differs) begin
            cnt_r <= '0;
          end else if (cnt_r == DB_LAST) begin
            cnt_r <= '0;
            level_r <= dbIn[g];
            edge_r <= 1'b1;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
      end
      assign dbOut[g] = level_r;
      assign dbEdge[g] = edge_r;
    end
  endgenerate

  // Management interrupt: lid either edge, or alert routed to it
  wire lidEvent = dbEdge[0] & pmCtl.lidSmiEn & ~pinSel.lidAsGpi;
  wire alertOn = pmCtl.alertEn & ~pinSel.alertAsGpi & ~gpiSync[SPC_GPI_ALERT];
  wire alertSmi = alertOn & (pmCtl.alertRoute == SPC_ROUTE_SMI);
  logic smiPend_r;
  // A new event in the clear cycle keeps the request pending
  wire smiPend_nxt = lidEvent | alertSmi | (smiPend_r & ~pmCtl.smiClear);

  // Throttle: base tick divider, then a programmable number of ticks per phase
  logic [7:0] tickCnt_r;
  logic [3:0] phaseCnt_r;
  logic throttlePhase_r;
  wire tick = tickCnt_r == TICK_LAST;
  wire throttling = pmCtl.throttleEn & ~pinSel.thermalAsGpi
                    & ~gpiSync[SPC_GPI_THERMAL];
  wire phaseEnd = tick & (phaseCnt_r == pmCtl.throttleRate);
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      tickCnt_r <= 8'h00;
      phaseCnt_r <= 4'h0;
      throttlePhase_r <= 1'b0;
    end else begin
      tickCnt_r <= tick ? 8'h00 : tickCnt_r + 8'h01;
      if (!throttling) begin
        phaseCnt_r <= 4'h0;
        throttlePhase_r <= 1'b0;
      end else if (phaseEnd) begin
        phaseCnt_r <= 4'h0;
        throttlePhase_r <= ~throttlePhase_r;
      end else if (tick) begin
        phaseCnt_r <= phaseCnt_r + 4'h1;
      end
    end
  end
  wire stopClock = pmCtl.stopClockReq | throttlePhase_r;

  // Plane and status decoding by suspend state
  wire inSuspend = sleepState != SPC_WORKING;
  wire inRamOrDisk = (sleepState == SPC_STR) | (sleepState == SPC_STD);
  wire inDisk = sleepState == SPC_STD;

  // General output register and I/O port
  logic [SPC_GPO_W-1:0] general_output_levels_r;
  wire hitGpi = pmIoSel & (pmIoAddr == SPC_OFF_GPI);
  wire hitGpo = pmIoSel & (pmIoAddr == SPC_OFF_GPO);
  wire [31:0] rdMux = hitGpi ? {10'h000, gpiSync}
                    : hitGpo ? {1'b0, general_output_levels_r} : 32'h0000_0000;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      general_output_levels_r <= SPC_GPO_RESET;
      pmIoRdData <= 32'h0000_0000;
      pmIoAck <= 1'b0;
    end else begin
      pmIoAck <= pmIoSel & (pmIoRd | pmIoWr);
      if (pmIoRd & pmIoSel) begin
        pmIoRdData <= rdMux;
      end
      if (pmIoWr & hitGpo) begin
        general_output_levels_r <= pmIoWrData[SPC_GPO_W-1:0];
      end
    end
  end

  // Dedicated function or general use per shared output pin
  logic [SPC_GPO_W-1:0] gpoPins;
  always_comb begin
    gpoPins = general_output_levels_r;
    if (!pinSel.planeBAsGpo) gpoPins[SPC_GPO_PLANE_B] = ~inRamOrDisk;
    if (!pinSel.planeCAsGpo) gpoPins[SPC_GPO_PLANE_C] = ~inDisk;
    if (!pinSel.busStopAsGpo) begin
      gpoPins[SPC_GPO_BUS_STOP] = ~(pmCtl.busStopReq | inRamOrDisk);
    end
    if (!pinSel.sramAsGpo) gpoPins[SPC_GPO_SRAM] = ~stopClock;
    if (!pinSel.hostStatAsGpo) begin
      gpoPins[SPC_GPO_HOST_STAT] = ~(stopClock | inSuspend);
    end
    if (!pinSel.periphAsGpo) gpoPins[SPC_GPO_PERIPH] = ~inSuspend;
    if (!pwrOkSync) gpoPins[SPC_GPO_POWEROFF] = 1'b0;
  end

  // Suspend-well pins: low while any reset holds, then state driven
  always_ff @(posedge sys_clk) begin
    if (anyRst) begin
      primary_plane_ctl_n <= 1'b0;
      secondary_plane_ctl_n <= 1'b0;
      tertiary_plane_ctl_n <= 1'b0;
      host_clock_status_n <= 1'b0;
      peripheral_suspend_status_n <= 1'b0;
      bus_clock_stop_n <= 1'b0;
      cache_sram_sleep_n <= 1'b0;
      general_output <= SPC_GPO_RESET;
    end else begin
      primary_plane_ctl_n <= ~inSuspend;
      secondary_plane_ctl_n <= gpoPins[SPC_GPO_PLANE_B];
      tertiary_plane_ctl_n <= gpoPins[SPC_GPO_PLANE_C];
      host_clock_status_n <= gpoPins[SPC_GPO_HOST_STAT];
      peripheral_suspend_status_n <= gpoPins[SPC_GPO_PERIPH];
      bus_clock_stop_n <= gpoPins[SPC_GPO_BUS_STOP];
      cache_sram_sleep_n <= gpoPins[SPC_GPO_SRAM];
      general_output <= gpoPins;
    end
  end

  // Core-side outputs: events, throttle, resets, decode and speaker
  wire cpuRstAssert = ~pwrOkSync;
  wire rstLevel = cpuTypeSync ? cpuRstAssert : ~cpuRstAssert;
  wire initLevel = cpuTypeSync ? cpuInitReq : ~cpuInitReq;
  wire topHit = memAddr[31:16] == SPC_BOOT_TOP;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      smiPend_r <= 1'b0;
      sys_mgmt_irq_n <= 1'b1;
      alertIrq <= 1'b0;
      alertResume <= 1'b0;
      powerButtonLevel <= 1'b1;
      cpu_clock_stop_req_n <= 1'b1;
      processor_reset <= 1'b0;
      processor_init <= 1'b0;
      bus_reset_n <= 1'b0;
      expansion_reset <= 1'b1;
      topRangePositive <= 1'b0;
      speaker_out <= 1'b0;
    end else begin
      smiPend_r <= smiPend_nxt;
      sys_mgmt_irq_n <= ~smiPend_nxt;
      alertIrq <= alertOn & (pmCtl.alertRoute == SPC_ROUTE_IRQ);
      alertResume <= alertOn & (pmCtl.alertRoute == SPC_ROUTE_RESUME);
      powerButtonLevel <= dbOut[1];
      cpu_clock_stop_req_n <= ~stopClock;
      processor_reset <= rstLevel;
      processor_init <= initLevel;
      bus_reset_n <= pwrOkSync;
      expansion_reset <= ~pwrOkSync;
      topRangePositive <= ~bootSelSync & topHit;
      speaker_out <= timer2Out & speakerGate;
    end
  end
endmodule : suspend_power_control

// ---- spc_far_side.sv ----
// Far-side model: clock generator and supply monitor around the suspend power block.
// Assumes the bench asks for power through powerOn and that sys_clk is shared.
`timescale 1ns/1ns
module spc_far_side #(
  parameter int STABLE_CYC = 10
) (
  // Clock and supply request
  input wire logic sys_clk,
  input wire logic powerOn,
  // Device pins
  input wire logic bus_clock_stop_n,
  output logic power_good,
  output logic busClkOn
);
  int stableCnt = 0;
  initial power_good = 1'b0;
  // Only the other bus clocks obey the stop pin
  assign busClkOn = bus_clock_stop_n;
  // The block's own clock is never gated here
  always @(posedge sys_clk) begin
    stableCnt <= powerOn ? stableCnt + 1 : 0;
    // Power good only once supply and clock have settled
    power_good <= powerOn && stableCnt >= STABLE_CYC;
  end
endmodule : spc_far_side

// ---- spc_checks_props.sv ----
// Checker for the suspend power control block: plane, status, reset and speaker pins.
// Assumes resume reset and power good change on sys_clk edges in simulation.
`timescale 1ns/1ns
module spc_checks
  import spc_pkg::*;
(
  // Clock and resets
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic resume_reset_n,
  input wire logic power_good,
  // Controls
  input wire spc_state_t sleepState,
  input wire spc_ctl_t pmCtl,
  input wire spc_pinsel_t pinSel,
  input wire logic cpu_type_select,
  input wire logic timer2Out,
  input wire logic speakerGate,
  // Observed pins
  input wire logic primary_plane_ctl_n,
  input wire logic secondary_plane_ctl_n,
  input wire logic tertiary_plane_ctl_n,
  input wire logic host_clock_status_n,
  input wire logic peripheral_suspend_status_n,
  input wire logic processor_reset,
  input wire logic bus_reset_n,
  input wire logic expansion_reset,
  input wire logic speaker_out
);
  logic [2:0] rsOk;
  wire awake = sleepState == SPC_WORKING;
  // Suspend-well pins lag the resume reset pin by its synchroniser
  always_ff @(posedge sys_clk) rsOk <= {rsOk[1:0], resume_reset_n};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  chk_primary_plane: assert property (&rsOk |=> primary_plane_ctl_n == $past(awake))
    else $error("primary plane control wrong");
  chk_secondary_plane: assert property (&rsOk && !pinSel.planeBAsGpo |=>
    secondary_plane_ctl_n == ($past(sleepState) inside {SPC_WORKING, SPC_POS}))
    else $error("secondary plane control wrong");
  chk_tertiary_plane: assert property (&rsOk && !pinSel.planeCAsGpo |=>
    tertiary_plane_ctl_n == ($past(sleepState) != SPC_STD))
    else $error("tertiary plane control wrong");
  chk_periph_status: assert property (&rsOk && !pinSel.periphAsGpo |=>
    peripheral_suspend_status_n == $past(awake))
    else $error("peripheral suspend status wrong");
  chk_host_status: assert property (&rsOk && !pinSel.hostStatAsGpo &&
    (!awake || pmCtl.stopClockReq) |=> !host_clock_status_n)
    else $error("host clock status not asserted");
  chk_pg_low_resets: assert property (!power_good [*3] |=> !bus_reset_n &&
    expansion_reset && processor_reset == $past(cpu_type_select))
    else $error("resets not asserted while power good low");
  chk_pg_high_release: assert property (power_good [*3] |=> bus_reset_n &&
    !expansion_reset)
    else $error("resets not released after power good");
  chk_speaker_gate: assert property (1'b1 |=> speaker_out == $past(timer2Out && speakerGate))
    else $error("speaker output wrong");
endmodule : spc_checks

bind suspend_power_control spc_checks chk (.*);

// ---- tb_suspend_power_control.sv ----
// Testbench for the suspend power control block against a small behavioural model.
// Assumes the far-side model supplies power_good; debounce is shortened to 8 cycles.
`timescale 1ns/1ns
module tb_suspend_power_control;
  import spc_pkg::*;
  localparam int DEB = 8;
  logic sys_clk = 0, reset_n = 0, resume_reset_n = 0, powerOn = 1, power_good, busClkOn;
  logic power_button_n = 1, cpu_type_select = 1;
  logic boot_range_decode_select = 0;
  logic cpuInitReq = 0, timer2Out = 0, speakerGate = 0, pmIoSel = 0, pmIoRd = 0, pmIoWr = 0;
  logic [21:0] general_input = 22'h3fffff;
  logic [31:0] memAddr = 32'h0, pmIoWrData = 32'h0, pmIoRdData, q, d;
  logic [7:0] pmIoAddr = 8'h0;
  spc_state_t sleepState = SPC_WORKING;
  spc_ctl_t pmCtl = '0;
  spc_pinsel_t pinSel = '0;
  logic pmIoAck, primary_plane_ctl_n, secondary_plane_ctl_n, tertiary_plane_ctl_n;
  logic host_clock_status_n, peripheral_suspend_status_n, bus_clock_stop_n, prev;
  logic cpu_clock_stop_req_n, sys_mgmt_irq_n, processor_reset, bus_reset_n;
  logic expansion_reset, speaker_out, cache_sram_sleep_n, alertIrq, alertResume;
  logic powerButtonLevel, processor_init, topRangePositive;
  logic [30:0] general_output;
  int seed = 32'h933137a3;
  int compares = 0, bad_count = 0, cycles = 0, n;
  suspend_power_control #(.DEBOUNCE_CYCLES(DEB)) uut (.*);
  spc_far_side #(.STABLE_CYC(10)) far (.sys_clk(sys_clk), .powerOn(powerOn),
    .bus_clock_stop_n(bus_clock_stop_n), .power_good(power_good), .busClkOn(busClkOn));
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 30000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task report_and_stop;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : tick
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One-cycle strobe; acknowledge and data follow one edge later
  task io(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    {pmIoSel, pmIoWr, pmIoRd, pmIoAddr, pmIoWrData} = {1'b1, wr, !wr, a, wd};
    tick(1);
    chk(pmIoAck, 1);
    q = pmIoRdData;
    // An idle cycle keeps back-to-back calls from re-driving the strobe in one step
    {pmIoSel, pmIoWr, pmIoRd} = 3'b000;
    tick(1);
  endtask : io
  // Pins per state code: plane A, B, C, host status, peripheral status, bus clock running
  function automatic logic [5:0] pins(input int s, input int stop);
    return {s == 0, s < 2, s != 2, s == 0 && stop == 0, s == 0, s < 2};
  endfunction : pins
  initial begin
    tick(12);
    resume_reset_n = 1;
    tick(4);
    reset_n = 1;
    tick(2);
    for (int i = 0; i < 8; i++) begin
      sleepState = spc_state_t'(i[1:0]);
      pmCtl.stopClockReq = i[2];
      tick(2);
      chk({primary_plane_ctl_n, secondary_plane_ctl_n, tertiary_plane_ctl_n, host_clock_status_n,
        peripheral_suspend_status_n, busClkOn}, pins(i % 4, i / 4));
      chk(cache_sram_sleep_n, i / 4 == 0);
    end
    chk({processor_init, powerButtonLevel, alertIrq, alertResume}, 4'b0100);
    {sleepState, pmCtl.stopClockReq} = '0;
    repeat (16) begin
      {timer2Out, speakerGate} = 2'($random(seed));
      memAddr = $random(seed) | (timer2Out ? 32'hffff0000 : 32'h0);
      tick(1);
      chk(speaker_out, timer2Out & speakerGate);
      chk(topRangePositive, memAddr[31:16] == 16'hffff);
    end
    general_input = 22'($random(seed)) | 22'h100;
    d = $random(seed);
    tick(3);
    io(0, SPC_OFF_GPI, 0);
    chk(q, {10'h0, general_input});
    io(1, SPC_OFF_GPO, d);
    io(1, SPC_OFF_GPI, ~d);
    io(0, SPC_OFF_GPO, 0);
    chk(q, {1'b0, d[30:0]});
    chk(general_output[7:0], d[7:0]);
    io(0, 8'h38, 0);
    chk(q, 0);
    powerOn = 0;
    tick(6);
    chk({bus_reset_n, expansion_reset, processor_reset, general_output[8]}, 4'b0110);
    powerOn = 1;
    tick(18);
    chk({bus_reset_n, expansion_reset}, 2'b10);
    pmCtl.lidSmiEn = 1;
    for (int k = 0; k < 2; k++) begin
      general_input[10] = ~general_input[10];
      tick(k == 0 ? 3 : DEB + 8);
    end
    chk(sys_mgmt_irq_n, 1);
    general_input[10] = ~general_input[10];
    tick(DEB + 8);
    chk(sys_mgmt_irq_n, 0);
    pmCtl.throttleEn = 1;
    general_input[SPC_GPI_THERMAL] = 0;
    n = 0;
    repeat (2048) begin
      prev = cpu_clock_stop_req_n;
      tick(1);
      n += int'(prev !== cpu_clock_stop_req_n);
    end
    chk(n >= 7 && n <= 8, 1);
    report_and_stop();
  end
endmodule : tb_suspend_power_control
